// >>> inc/rpw_pkg.sv
// constants, types and register map of the reverse power stage
// assumes one 200 mhz clock and a word-addressed avalon-mm slave
package rpw_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ        = 200_000_000;
  localparam int PROG_CYCLE_US = 5000;
  localparam int STAMP_US      = 1000;
  localparam int BLOCK_LEAD_US = 5000;
  localparam int PRE_TRIG_US   = 20000;
  localparam int PRE_FAULT_US  = 200000;
  localparam int PROG_DIV_DEF  = CLK_HZ / 1_000_000 * PROG_CYCLE_US;
  localparam int MS_DIV_DEF    = CLK_HZ / 1_000_000 * STAMP_US;
  localparam int PRE_TRIG_TAP  = PRE_TRIG_US / PROG_CYCLE_US;
  localparam int PRE_FAULT_TAP = PRE_FAULT_US / PROG_CYCLE_US;
  // ---------------------------------------------------------------
  // widths and scaling
  // ---------------------------------------------------------------
  localparam int PW          = 32;
  localparam int TW          = 20;
  localparam int CW          = 16;
  localparam int SW          = 32;
  localparam int RESET_PCT   = 97;
  localparam int RATIO_SCALE = 100;
  localparam int REC_DEPTH   = 12;
  localparam int REC_FIELDS  = 7;
  // ---------------------------------------------------------------
  // events and record codes
  // ---------------------------------------------------------------
  localparam int EV_START_ON  = 0;
  localparam int EV_START_OFF = 1;
  localparam int EV_TRIP_ON   = 2;
  localparam int EV_TRIP_OFF  = 3;
  localparam int EV_BLK_ON    = 4;
  localparam int EV_BLK_OFF   = 5;
  localparam int EV_N         = 6;
  localparam logic [2:0] CODE_START = 3'h1;
  localparam logic [2:0] CODE_TRIP  = 3'h2;
  localparam logic [2:0] CODE_BLK   = 3'h3;
  // ---------------------------------------------------------------
  // register map (word addresses)
  // ---------------------------------------------------------------
  localparam logic [6:0] OFS_CTRL   = 7'h00;
  localparam logic [6:0] OFS_EVT_EN = 7'h01;
  localparam logic [6:0] OFS_PSET   = 7'h02;
  localparam logic [6:0] OFS_OP_DLY = 7'h03;
  localparam logic [6:0] OFS_RS_DLY = 7'h04;
  localparam logic [6:0] OFS_SGRP   = 7'h05;
  localparam logic [6:0] OFS_STATUS = 7'h06;
  localparam logic [6:0] OFS_REMAIN = 7'h07;
  localparam logic [6:0] OFS_EXPECT = 7'h08;
  localparam logic [6:0] OFS_RATIO  = 7'h09;
  localparam logic [6:0] OFS_CNT_ST = 7'h0a;
  localparam logic [6:0] OFS_CNT_TR = 7'h0b;
  localparam logic [6:0] OFS_CNT_BL = 7'h0c;
  localparam logic [6:0] OFS_TIME   = 7'h0d;
  localparam logic [6:0] OFS_RECPTR = 7'h0e;
  localparam logic [3:0] REC_ROW0   = 4'h2;
  localparam int         CTRL_CLR   = 0;
  localparam logic [EV_N-1:0] EVT_EN_RST = 6'h3f;
  localparam logic [PW-1:0]   PSET_RST   = 32'h0000_2710;
  localparam logic [TW-1:0]   OP_DLY_RST = 20'h000c8;
  localparam logic [TW-1:0]   RS_DLY_RST = 20'h00000;
  localparam logic [2:0]      SGRP_RST   = 3'h1;
  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {COND_NORMAL, COND_START, COND_TRIP, COND_BLOCKED} cond_t;
  typedef struct packed {
    logic [6:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } av_req_t;
  typedef struct packed {
    logic [EV_N-1:0] flags;
    logic [SW-1:0]   stamp;
  } evt_t;
  typedef struct packed {
    logic [SW-1:0] stamp;
    logic [2:0]    code;
    logic [PW-1:0] pre_trig;
    logic [PW-1:0] fault;
    logic [PW-1:0] pre_fault;
    logic [TW-1:0] remain;
    logic [2:0]    group;
  } rec_t;
endpackage

// >>> src/tick_div.sv
// one-cycle enable pulse every DIV clocks
// assumes a synchronous active-high reset
`timescale 1ns/1ps
`default_nettype none
module tick_div
  import rpw_pkg::*;
#(
  parameter int DIV = PROG_DIV_DEF // clocks per pulse
)(
  input  wire logic clk,  // system clock
  input  wire logic srst, // sync reset
  output logic      tick  // one-cycle enable
);
  localparam int CNW = $clog2(DIV);
  localparam logic [CNW-1:0] LAST = CNW'(DIV - 1);

  if (DIV < 2)
  begin : g_bad
    $error("tick_div: DIV must be at least 2");
  end

  logic [CNW-1:0] cnt_r;
  wire logic      wrap = (cnt_r == LAST);

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end
    else
    begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end
endmodule // tick_div
`default_nettype wire

// >>> src/reverse_power_event_block.sv
// reverse power stage: pick-up, definite-time timing, events, counters, records
// assumes synchronous inputs, one clock, word-addressed avalon-mm slave
//
// Behaviour
// - blocking input is sampled at each program cycle start, before evaluation.
// - pick-up without blocking raises start and starts operate timing.
// - pick-up while blocked raises blocked and nothing else happens.
// - blocking after start clears start and runs release timing like drop-out.
// - only definite-time operate and reset delays exist.
// - start, trip and blocked each give separate on and off events.
// - per-event enable selects which events reach the event output.
// - every event carries a one millisecond time stamp.
// - resettable counters count start, trip and blocked occurrences.
// - exactly one stage instance exists.
// - twelve records kept circularly, newest overwrites oldest.
// - record on each on event: stamp, event, powers, remaining time, group.
// - readable condition: normal, start, trip or blocked.
// - remaining and expected operate time readable in 5 ms steps.
// - readable power to setting ratio in steps of 0.01.
// - pick-up when measured power exceeds the reverse power setting.
// - drop-out below 97 percent of the setting.
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module reverse_power_event_block
  import rpw_pkg::*;
#(
  parameter int PROG_DIV = PROG_DIV_DEF, // clocks per program cycle
  parameter int MS_DIV   = MS_DIV_DEF    // clocks per stamp millisecond
)(
  input  wire logic          clk,                   // 200 mhz clock
  input  wire logic          srst,                  // sync reset, high
  input  wire av_req_t       bus,                   // avalon request
  output logic [31:0]        readdata,              // avalon read data
  output logic               waitrequest,           // avalon wait
  input  wire logic [PW-1:0] measured_active_power, // reverse power, 0.01 kw
  input  wire logic          block_in,              // blocking matrix input
  output logic               start,                 // start status
  output logic               trip,                  // trip status
  output logic               blocked,               // blocked status
  output evt_t               evt,                   // event flags and stamp
  output logic               evt_valid              // event pulse
);
  localparam int HD = PRE_FAULT_TAP + 1;
  localparam int PX = PW + 7;

  if (PROG_DIV < 2 || MS_DIV < 2 || PRE_TRIG_TAP >= HD)
  begin : g_bad
    $error("reverse_power_event_block: bad divider or tap setting");
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ---------------------------------------------------------------
  // ticks
  // ---------------------------------------------------------------
  logic prog_tick;
  logic ms_tick;
  tick_div #(.DIV(PROG_DIV)) u_prog (.clk(clk), .srst(srst), .tick(prog_tick));
  tick_div #(.DIV(MS_DIV))   u_ms   (.clk(clk), .srst(srst), .tick(ms_tick));

  // ---------------------------------------------------------------
  // avalon slave: one wait cycle per access
  // ---------------------------------------------------------------
  logic [EV_N-1:0] evt_en_r;
  logic [PW-1:0]   pset_r;
  logic [TW-1:0]   op_dly_r;
  logic [TW-1:0]   rs_dly_r;
  logic [2:0]      sgrp_r;
  logic [SW-1:0]   ms_cnt_r;
  logic [31:0]     rd_mux;
  logic [31:0]     ratio_r;
  logic [CW-1:0]   cnt_r [3];
  logic [3:0]      wp_r;
  rec_t            rec_mem [REC_DEPTH];
  cond_t           st_r;
  logic [TW-1:0]   rem_r;

  wire logic       req     = bus.read | bus.write;
  wire logic       wr_go   = bus.write & ~waitrequest;
  wire logic [6:0] a       = bus.address;
  wire logic [3:0] rec_e   = a[6:3] - REC_ROW0;
  wire logic       rec_hit = (a[6:3] >= REC_ROW0) && (rec_e < 4'(REC_DEPTH)) && (a[2:0] < 3'(REC_FIELDS));
  wire rec_t       rec_s   = rec_mem[rec_hit ? rec_e : 4'h0];
  wire logic       cnt_clr = wr_go && (a == OFS_CTRL) && bus.writedata[CTRL_CLR];

  always_comb
  begin
    rd_mux = '0;
    if (rec_hit)
    begin
      case (a[2:0])
        3'h0:    rd_mux = rec_s.stamp;
        3'h1:    rd_mux = 32'(rec_s.code);
        3'h2:    rd_mux = rec_s.pre_trig;
        3'h3:    rd_mux = rec_s.fault;
        3'h4:    rd_mux = rec_s.pre_fault;
        3'h5:    rd_mux = 32'(rec_s.remain);
        default: rd_mux = 32'(rec_s.group);
      endcase
    end
    else
    begin
      case (a)
        OFS_EVT_EN: rd_mux = 32'(evt_en_r);
        OFS_PSET:   rd_mux = pset_r;
        OFS_OP_DLY: rd_mux = 32'(op_dly_r);
        OFS_RS_DLY: rd_mux = 32'(rs_dly_r);
        OFS_SGRP:   rd_mux = 32'(sgrp_r);
        OFS_STATUS: rd_mux = 32'(st_r);
        OFS_REMAIN: rd_mux = 32'(rem_r);
        OFS_EXPECT: rd_mux = 32'(op_dly_r);
        OFS_RATIO:  rd_mux = ratio_r;
        OFS_CNT_ST: rd_mux = 32'(cnt_r[0]);
        OFS_CNT_TR: rd_mux = 32'(cnt_r[1]);
        OFS_CNT_BL: rd_mux = 32'(cnt_r[2]);
        OFS_TIME:   rd_mux = ms_cnt_r;
        OFS_RECPTR: rd_mux = 32'(wp_r);
        default:    rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      waitrequest <= 1'b1;
      readdata    <= '0;
    end
    else
    begin
      waitrequest <= ~(req & waitrequest);
      if (req && waitrequest)
        readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      evt_en_r <= EVT_EN_RST;
      pset_r   <= PSET_RST;
      op_dly_r <= OP_DLY_RST;
      rs_dly_r <= RS_DLY_RST;
      sgrp_r   <= SGRP_RST;
    end
    else if (wr_go)
    begin
      case (a)
        OFS_EVT_EN: evt_en_r <= bus.writedata[EV_N-1:0];
        OFS_PSET:   pset_r   <= bus.writedata[PW-1:0];
        OFS_OP_DLY: op_dly_r <= bus.writedata[TW-1:0];
        OFS_RS_DLY: rs_dly_r <= bus.writedata[TW-1:0];
        OFS_SGRP:   sgrp_r   <= bus.writedata[2:0];
        default:    ;
      endcase
    end
  end

  // millisecond time base, software sets the time of day
  always_ff @(posedge clk)
  begin
    if (srst)
      ms_cnt_r <= '0;
    else if (wr_go && a == OFS_TIME)
      ms_cnt_r <= bus.writedata[SW-1:0];
    else if (ms_tick)
      ms_cnt_r <= ms_cnt_r + 1'b1;
  end

  // ---------------------------------------------------------------
  // sampling and pick-up
  // ---------------------------------------------------------------
  logic [PW-1:0] hist_r [HD];
  logic          blk_r;
  logic          eval_r;
  logic          pu_r;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      blk_r  <= 1'b0;
      eval_r <= 1'b0;
      for (int i = 0; i < HD; i++)
        hist_r[i] <= '0;
    end
    else
    begin
      eval_r <= prog_tick;
      if (prog_tick)
      begin
        blk_r     <= block_in;
        hist_r[0] <= measured_active_power;
        for (int i = 1; i < HD; i++)
          hist_r[i] <= hist_r[i-1];
      end
    end
  end

  wire logic [PX-1:0] pw100  = PX'(hist_r[0]) * PX'(RATIO_SCALE);
  wire logic [PX-1:0] ps97   = PX'(pset_r) * PX'(RESET_PCT);
  wire logic          pu_on  = hist_r[0] > pset_r;
  wire logic          pu_off = pw100 < ps97;
  wire logic          pu_now = pu_on | (pu_r & ~pu_off);
  wire logic          fault  = pu_now & ~blk_r;

  // ---------------------------------------------------------------
  // definite-time state machine, single stage
  // ---------------------------------------------------------------
  cond_t         st_nxt;
  logic [TW-1:0] rem_nxt;
  logic [TW-1:0] rel_r;
  logic [TW-1:0] rel_nxt;

  always_comb
  begin
    st_nxt  = st_r;
    rem_nxt = rem_r;
    rel_nxt = rel_r;
    if (eval_r)
    begin
      unique case (st_r)
        COND_NORMAL:
        begin
          if (fault)
          begin
            st_nxt  = COND_START;
            rem_nxt = (rel_r != '0) ? rem_r : op_dly_r;
            rel_nxt = '0;
          end
          else if (pu_now)
            st_nxt = COND_BLOCKED;
          else if (rel_r != '0)
            rel_nxt = rel_r - 1'b1;
          else
            rem_nxt = op_dly_r;
        end
        COND_START:
        begin
          if (!fault)
          begin
            st_nxt  = COND_NORMAL;
            rel_nxt = rs_dly_r;
          end
          else if (rem_r <= TW'(1))
          begin
            st_nxt  = COND_TRIP;
            rem_nxt = '0;
            rel_nxt = rs_dly_r;
          end
          else
            rem_nxt = rem_r - 1'b1;
        end
        COND_TRIP:
        begin
          if (fault)
            rel_nxt = rs_dly_r;
          else if (rel_r == '0)
          begin
            st_nxt  = COND_NORMAL;
            rem_nxt = op_dly_r;
          end
          else
            rel_nxt = rel_r - 1'b1;
        end
        COND_BLOCKED:
        begin
          if (!pu_now)
            st_nxt = COND_NORMAL;
          rel_nxt = '0;
        end
      endcase
    end
  end

  wire logic s_n = (st_nxt == COND_START) || (st_nxt == COND_TRIP);
  wire logic t_n = (st_nxt == COND_TRIP);
  wire logic b_n = (st_nxt == COND_BLOCKED);
  wire logic [EV_N-1:0] ev = {blocked & ~b_n, ~blocked & b_n, trip & ~t_n, ~trip & t_n,
                              start & ~s_n, ~start & s_n};

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      st_r      <= COND_NORMAL;
      rem_r     <= '0;
      rel_r     <= '0;
      pu_r      <= 1'b0;
      start     <= 1'b0;
      trip      <= 1'b0;
      blocked   <= 1'b0;
      evt_valid <= 1'b0;
      evt       <= '0;
      ratio_r   <= '0;
    end
    else
    begin
      st_r      <= st_nxt;
      rem_r     <= rem_nxt;
      rel_r     <= rel_nxt;
      start     <= s_n;
      trip      <= t_n;
      blocked   <= b_n;
      evt_valid <= |(ev & evt_en_r);
      evt.flags <= ev & evt_en_r;
      evt.stamp <= ms_cnt_r;
      if (eval_r)
      begin
        pu_r    <= pu_now;
        ratio_r <= (pset_r == '0) ? '1 : 32'(pw100 / PX'(pset_r));
      end
    end
  end

  // ---------------------------------------------------------------
  // counters and records
  // ---------------------------------------------------------------
  wire logic [2:0] inc    = {ev[EV_BLK_ON], ev[EV_TRIP_ON], ev[EV_START_ON]};
  wire logic       rec_wr = |inc;
  wire logic [2:0] code   = ev[EV_TRIP_ON] ? CODE_TRIP : ev[EV_START_ON] ? CODE_START : CODE_BLK;

  always_ff @(posedge clk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (srst)
        cnt_r[i] <= '0;
      else if (inc[i])
        cnt_r[i] <= cnt_clr ? CW'(1) : cnt_r[i] + 1'b1;
      else if (cnt_clr)
        cnt_r[i] <= '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      wp_r <= '0;
      for (int i = 0; i < REC_DEPTH; i++)
        rec_mem[i] <= '0;
    end
    else if (rec_wr)
    begin
      rec_mem[wp_r] <= '{stamp: ms_cnt_r, code: code, pre_trig: hist_r[PRE_TRIG_TAP],
                         fault: hist_r[0], pre_fault: hist_r[PRE_FAULT_TAP],
                         remain: rem_nxt, group: sgrp_r};
      wp_r <= (wp_r == 4'(REC_DEPTH - 1)) ? '0 : wp_r + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  a_blk_sample: assert property (prog_tick |=> blk_r == $past(block_in))
    else $error("blocking input not sampled at program cycle");
  a_start_clean: assert property (eval_r && st_r == COND_NORMAL && pu_now && !blk_r |=> start && !blocked)
    else $error("pick-up without block did not start");
  a_block_hold: assert property (eval_r && st_r == COND_NORMAL && pu_now && blk_r |=> blocked ##1 !start)
    else $error("blocked pick-up acted");
  a_block_release: assert property (eval_r && st_r == COND_START && blk_r |=> !start && rel_r == $past(rs_dly_r))
    else $error("block after start did not release");
  a_rem_step: assert property (eval_r && st_r == COND_START && fault && rem_r > TW'(1) |=> rem_r == $past(rem_r) - 1'b1)
    else $error("remaining time did not step");
  a_trip_zero: assert property ($rose(trip) |-> rem_r == '0 && $past(st_r) == COND_START)
    else $error("trip without expired delay");
  a_evt_on: assert property ($rose(start) && $past(evt_en_r[EV_START_ON]) |-> evt_valid && evt.flags[EV_START_ON])
    else $error("start on event missing");
  a_evt_filter: assert property (evt_valid |-> (evt.flags & ~$past(evt_en_r)) == '0)
    else $error("disabled event passed");
  a_evt_stamp: assert property (evt_valid |-> evt.stamp == $past(ms_cnt_r))
    else $error("event stamp wrong");
  a_cnt_trip: assert property ($rose(trip) && !$past(cnt_clr) |-> cnt_r[1] == $past(cnt_r[1]) + 1'b1)
    else $error("trip counter did not count");
  a_rec_fault: assert property ($rose(start) |-> rec_mem[$past(wp_r)].fault == $past(hist_r[0]))
    else $error("record fault power wrong");
  a_rec_wrap: assert property (rec_wr && wp_r == 4'(REC_DEPTH - 1) |=> wp_r == '0)
    else $error("record pointer did not wrap");
endmodule // reverse_power_event_block
`default_nettype wire

// >>> test/power_source.sv
// partner model: power front end and blocking matrix output
// assumes the bench sets its commands; outputs change on rising clk edges only
`timescale 1ns/1ps
`default_nettype none
module power_source
  import rpw_pkg::*;
(
  input  wire logic          clk,                   // system clock
  input  wire logic [PW-1:0] power_cmd,             // wanted power
  input  wire logic          block_cmd,             // wanted blocking
  output logic [PW-1:0]      measured_active_power, // power to the stage
  output logic               block_in               // blocking to the stage
);
  // power and blocking commands reach the stage one clock later, through one register
  always_ff @(posedge clk)
  begin
    measured_active_power <= power_cmd;
    block_in              <= block_cmd;
  end
endmodule // power_source
`default_nettype wire

// >>> test/reverse_power_event_block_bench.sv
// self-checking bench of the reverse power stage
// assumes short dividers: 20 clocks per program cycle, 4 clocks per stamp ms
`timescale 1ns/1ps
`default_nettype none
module reverse_power_event_block_bench;
  import rpw_pkg::*;
  localparam int PDIV = 20;
  localparam int MDIV = 4;
  logic          clk = 1'b0;
  logic          srst = 1'b1;
  av_req_t       bus = '0;
  logic [31:0]   readdata;
  logic          waitrequest;
  logic [PW-1:0] power_cmd = '0;
  logic          block_cmd = 1'b0;
  logic [PW-1:0] mpower;
  logic          blk;
  logic          start;
  logic          trip;
  logic          blocked;
  evt_t          evt;
  logic          evt_valid;
  logic [31:0]   stamp_now;
  logic [31:0]   st0;
  int            err_count = 0;
  int            total_checks = 0;

  always #2.5 clk = ~clk;

  power_source power_source_i (.clk(clk), .power_cmd(power_cmd), .block_cmd(block_cmd),
    .measured_active_power(mpower), .block_in(blk));

  reverse_power_event_block #(.PROG_DIV(PDIV), .MS_DIV(MDIV)) reverse_power_event_block_i (
    .clk(clk), .srst(srst), .bus(bus), .readdata(readdata), .waitrequest(waitrequest),
    .measured_active_power(mpower), .block_in(blk), .start(start), .trip(trip),
    .blocked(blocked), .evt(evt), .evt_valid(evt_valid));

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic tally_and_finish;
    if (err_count == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask

  // waits for the next event pulse, then compares its flags
  task automatic chk_flags(input logic [EV_N-1:0] exp);
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (evt_valid !== 1'b1 && n < 400);
    stamp_now = evt.stamp;
    total_checks++;
    if (n >= 400 || evt.flags !== exp)
    begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, evt.flags, exp);
      err_count++;
    end
  endtask

  // ---------------------------------------------------------------
  // avalon-mm access, entered just after a rising edge
  // ---------------------------------------------------------------
  task automatic access(input logic [6:0] a, input logic rd, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    bus <= '{a, rd, !rd, d};
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    bus <= '0;
    @(posedge clk);
    chk_word(32'(n < 50), 32'h1);
  endtask

  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(a, 1'b0, d, q);
  endtask

  task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] q;
    access(a, 1'b1, '0, q);
    chk_word(q, exp);
  endtask

  // ---------------------------------------------------------------
  // watchdog
  // ---------------------------------------------------------------
  initial
  begin
    #40000;
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
    err_count++;
    tally_and_finish();
  end

  // ---------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------
  initial
  begin
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    rdc(OFS_EVT_EN, 32'h3f);
    rdc(OFS_PSET, 32'h2710);
    rdc(OFS_SGRP, 32'h1);
    rdc(OFS_STATUS, 32'h0);
    rdc(7'h0f, 32'h0);
    wr(OFS_OP_DLY, 32'h3);
    wr(OFS_RS_DLY, 32'h0);
    rdc(OFS_EXPECT, 32'h3);
    // start, then trip after three evaluations
    power_cmd <= 32'h4e20;
    chk_flags(6'h01);
    st0 = stamp_now;
    rdc(OFS_REMAIN, 32'h3);
    rdc(OFS_RATIO, 32'hc8);
    rdc(OFS_STATUS, 32'h1);
    chk_flags(6'h04);
    chk_word(32'({start, trip, blocked}), 32'h6);
    chk_word(stamp_now - st0, 32'hf);
    rdc(OFS_REMAIN, 32'h0);
    rdc(OFS_STATUS, 32'h2);
    rdc(OFS_RECPTR, 32'h2);
    rdc(7'h11, 32'h1);
    rdc(7'h13, 32'h4e20);
    rdc(7'h19, 32'h2);
    rdc(7'h1e, 32'h1);
    power_cmd <= 32'h0;
    chk_flags(6'h0a);
    // blocking after start, then pick-up while blocked
    power_cmd <= 32'h4e20;
    chk_flags(6'h01);
    block_cmd <= 1'b1;
    chk_flags(6'h02);
    chk_flags(6'h10);
    power_cmd <= 32'h0;
    chk_flags(6'h20);
    block_cmd <= 1'b0;
    // pick-up and drop-out boundaries with only start-off enabled
    wr(OFS_EVT_EN, 32'h2);
    wr(OFS_OP_DLY, 32'h64);
    power_cmd <= 32'h2710;
    repeat (3 * PDIV) @(posedge clk);
    rdc(OFS_STATUS, 32'h0);
    power_cmd <= 32'h2711;
    repeat (3 * PDIV) @(posedge clk);
    rdc(OFS_STATUS, 32'h1);
    power_cmd <= 32'h25e4;
    repeat (3 * PDIV) @(posedge clk);
    rdc(OFS_STATUS, 32'h1);
    power_cmd <= 32'h25e3;
    chk_flags(6'h02);
    // counters and their clear
    rdc(OFS_CNT_ST, 32'h3);
    rdc(OFS_CNT_TR, 32'h1);
    rdc(OFS_CNT_BL, 32'h1);
    rdc(OFS_RECPTR, 32'h5);
    wr(OFS_CTRL, 32'h1);
    rdc(OFS_CNT_ST, 32'h0);
    rdc(OFS_CNT_BL, 32'h0);
    // reset delay of two cycles holds trip through two drop-out evaluations, it clears on the third
    wr(OFS_EVT_EN, 32'h3f);
    wr(OFS_RS_DLY, 32'h2);
    wr(OFS_OP_DLY, 32'h1);
    power_cmd <= 32'h4e21;
    chk_flags(6'h01);
    chk_flags(6'h04);
    st0 = stamp_now;
    power_cmd <= 32'h0;
    chk_flags(6'h0a);
    chk_word(stamp_now - st0, 32'hf);
    // blocked pick-ups until the record history wraps past entry 0
    block_cmd <= 1'b1;
    repeat (6)
    begin
      power_cmd <= 32'h4e22;
      chk_flags(6'h10);
      chk_word(32'({start, trip, blocked}), 32'h1);
      power_cmd <= 32'h0;
      chk_flags(6'h20);
    end
    block_cmd <= 1'b0;
    rdc(OFS_RECPTR, 32'h1);
    rdc(7'h11, 32'h3);
    rdc(7'h13, 32'h4e22);
    rdc(OFS_CNT_BL, 32'h6);
    chk_word(32'({start, trip, blocked}), 32'h0);
    tally_and_finish();
  end
endmodule // reverse_power_event_block_bench
`default_nettype wire
